// ===== hw/flash_host_defines.svh
// Timing counts, pin field positions and codes for the parallel flash host
`ifndef FLASH_HOST_DEFINES_SVH
`define FLASH_HOST_DEFINES_SVH

`define CLK_PERIOD_NS        50
`define T_ACCESS_NS          90
`define T_PAGE_NS            30
`define T_WE_LOW_NS          50
`define T_WE_HIGH_NS         50
`define T_RESET_PULSE_NS     500
`define T_READY_MAX_NS       20000
`define T_RECOVER_NS         50
`define CYC_UP(ns)           (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Two sync stages sit between the pins and the captured read data
`define ACCESS_CYC           8'(`CYC_UP(`T_ACCESS_NS) + 2)
`define PAGE_CYC             8'(`CYC_UP(`T_PAGE_NS) + 2)
`define WE_LOW_CYC           8'(`CYC_UP(`T_WE_LOW_NS))
`define WE_HIGH_CYC          8'(`CYC_UP(`T_WE_HIGH_NS))
`define RESET_PULSE_CYC      16'(`CYC_UP(`T_RESET_PULSE_NS))
`define READY_MAX_CYC        16'(`T_READY_MAX_NS / `CLK_PERIOD_NS)
`define RECOVER_CYC          8'(`CYC_UP(`T_RECOVER_NS))
`define SECTOR_MSB           22
`define SECTOR_LSB           16
`define PAGE_LSB             3
`define ID_PIN_BIT           9
`define LOCK_ADDR_LOW        7'h02
`define MFR_ADDR_LOW         7'h00
`define ID1_ADDR_LOW         7'h01
`define ID2_ADDR_LOW         7'h0e
`define ID3_ADDR_LOW         7'h0f

`endif

// ===== hw/flash_host_pkg.sv
// Types shared by the parallel flash host
package flash_host_pkg;
  typedef enum logic [2:0] {
    CMD_READ,
    CMD_WRITE,
    CMD_LOCK_STATUS,
    CMD_ID_READ,
    CMD_RESET
  } cmd_e;
  typedef logic [22:0] addr_t;
  typedef logic [15:0] data_t;
endpackage

// ===== hw/pin_sync.sv
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_reg <= '0;
      o_sync   <= '0;
    end else begin
      meta_reg <= i_async;
      o_sync   <= meta_reg;
    end
  end
endmodule // pin_sync

// ===== hw/flash_host.sv
// Host controller driving a parallel NOR flash through its pins
// How it works
// (RL1) Sector index sits on address bits 22..16, 128 sectors of 64 Kwords.
// (RL2) Reads drive chip select and output enable low, write strobe high.
// (RL3) Flash floats data while chip select or output enable is high.
// (RL4) Page is 8 words; bits 3 and up pick page, low bits pick word.
// (RL5) First page access waits full time, same-page reads wait page time.
// (RL6) Flash takes address at strobe fall, data at strobe rise.
// (RL7) Writes hold chip select low, output enable high, pulse strobe low.
// (RL8) Only defined command codes may be written to the flash.
// (RL9) Reset pin held low at least the minimum pulse returns read mode.
// (RL10) After reset, ready/busy stays low up to the recovery maximum.
// (RL11) System reset also drives the flash reset pin.
// (RL12) With chip select high the flash is in standby and ignores strobes.
// (RL13) Output enable high with chip select low leaves data floating.
// (RL14) Width select high means word mode on all 16 data lines.
// (RL15) Width select low: byte data on 0..7, line 15 is byte address.
// (RL16) Protect pin low blocks program and erase of outermost sector.
// (RL17) Protect pin high restores outermost sector's earlier protection.
// (RL18) Data pins are inputs or outputs depending on operation.
// (RL19) Lock status read returns 0 unprotected, bit 0 set when protected.
// (RL20) High-voltage identification read returns maker code on low byte.
// (RL21) Protect pin at high voltage enables accelerated programming; the host's accel input only drives the pin to logic high.
// (RL22) Three high-voltage reads return the three-word device code.
`timescale 1ns/100ps
`include "flash_host_defines.svh"
module flash_host
  import flash_host_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_req_valid,
  output logic             o_req_ready,
  input  wire logic [2:0]  i_req_cmd,
  input  wire logic [22:0] i_req_addr,
  input  wire logic        i_req_byte_addr,
  input  wire logic [15:0] i_req_wdata,
  input  wire logic        i_word_mode,
  input  wire logic        i_protect,
  input  wire logic        i_accel,
  output logic             o_rsp_valid,
  output logic      [15:0] o_rsp_rdata,
  output logic             o_busy,
  output logic             o_reset_timeout,
  output logic      [22:0] o_addr,
  output logic             o_chip_sel_n,
  output logic             o_out_en_n,
  output logic             o_write_n,
  output logic             o_reset_n,
  output logic             o_word_mode,
  output logic             o_protect_accel_pin,
  output logic             o_id_high_volt,
  input  wire logic [15:0] i_data,
  output logic      [15:0] o_data,
  output logic      [15:0] o_data_oe,
  output logic             o_msb_data_or_byte_addr,
  output logic             o_msb_oe,
  input  wire logic        i_ready_busy_out
);

  // ****************************************************************
  // State and registers
  // ****************************************************************
  typedef enum {
    ST_RESET_PULSE, ST_RESET_WAIT, ST_IDLE, ST_READ, ST_WR_LOW,
    ST_WR_HIGH, ST_RECOVER
  } state_e;

  state_e      state_reg;
  logic [15:0] cnt_reg;
  logic        page_valid_reg;
  logic [19:0] page_tag_reg;
  logic        word_mode_reg;
  logic        byte_addr_reg;
  logic [15:0] wdata_reg;
  logic        rdy_sync;
  logic [15:0] data_sync;
  logic [16:0] sync_in;

  assign sync_in = {i_ready_busy_out, i_data};

  pin_sync #(.W(17)) u_sync (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_async (sync_in),
    .o_sync  ({rdy_sync, data_sync})
  );

  function automatic logic same_page(input logic [22:0] a,
                                     input logic [19:0] tag);
    same_page = (a[22:`PAGE_LSB] == tag);
  endfunction

  // Low address pattern for the identification reads
  function automatic logic [6:0] id_low(input logic [22:0] a);
    id_low = {1'b0, 2'b00, a[3:0]};
  endfunction

  assign o_req_ready = (state_reg == ST_IDLE);

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg      <= ST_RESET_PULSE;
      cnt_reg        <= 16'h0000;
      page_valid_reg <= 1'b0;
      page_tag_reg   <= 20'h00000;
      o_addr         <= 23'h000000;
      o_chip_sel_n   <= 1'b1;
      o_out_en_n     <= 1'b1;
      o_write_n      <= 1'b1;
      o_reset_n      <= 1'b0;                       // [RL11]
      o_id_high_volt <= 1'b0;
      o_rsp_valid    <= 1'b0;
      o_rsp_rdata    <= 16'h0000;
      o_reset_timeout <= 1'b0;
      wdata_reg      <= 16'h0000;
      byte_addr_reg  <= 1'b0;
    end else begin
      o_rsp_valid <= 1'b0;
      case (state_reg)
        ST_RESET_PULSE: begin
          o_reset_n <= 1'b0;
          cnt_reg   <= cnt_reg + 16'h0001;
          if (cnt_reg + 16'h0001 >= `RESET_PULSE_CYC) begin // [RL9]
            o_reset_n <= 1'b1;
            cnt_reg   <= 16'h0000;
            state_reg <= ST_RESET_WAIT;
          end
        end
        ST_RESET_WAIT: begin
          cnt_reg <= cnt_reg + 16'h0001;
          // Wait for ready, or give up at the ready maximum and flag a timeout, before using the bus [RL10]
          if (cnt_reg >= 16'h0003 && rdy_sync) begin
            state_reg <= ST_IDLE;
          end else if (cnt_reg >= `READY_MAX_CYC) begin
            o_reset_timeout <= 1'b1;
            state_reg       <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          cnt_reg <= 16'h0000;
          if (i_req_valid) begin
            o_addr        <= i_req_addr;
            byte_addr_reg <= i_req_byte_addr;
            wdata_reg     <= i_req_wdata;
            o_id_high_volt <= 1'b0;
            case (cmd_e'(i_req_cmd))
              CMD_READ: begin
                o_chip_sel_n <= 1'b0;               // [RL2]
                o_out_en_n   <= 1'b0;
                o_write_n    <= 1'b1;
                // Same page and chip still selected: page time [RL4] [RL5]
                if (page_valid_reg && !o_chip_sel_n &&
                    same_page(i_req_addr, page_tag_reg)) begin
                  cnt_reg <= 16'(`ACCESS_CYC - `PAGE_CYC);
                end
                page_tag_reg   <= i_req_addr[22:`PAGE_LSB];
                page_valid_reg <= 1'b1;
                state_reg      <= ST_READ;
              end
              CMD_LOCK_STATUS, CMD_ID_READ: begin
                // Sector index stays on bits 22..16 [RL1] [RL19]
                // Id reads pass the low request bits [RL20] [RL22]
                o_addr[`ID_PIN_BIT] <= 1'b1;
                o_addr[6:0] <= (cmd_e'(i_req_cmd) == CMD_LOCK_STATUS) ?
                               `LOCK_ADDR_LOW : id_low(i_req_addr);
                o_id_high_volt <= 1'b1;
                o_chip_sel_n   <= 1'b0;
                o_out_en_n     <= 1'b0;
                page_valid_reg <= 1'b0;
                state_reg      <= ST_READ;
              end
              CMD_WRITE: begin
                o_chip_sel_n   <= 1'b0;             // [RL7]
                o_out_en_n     <= 1'b1;
                o_write_n      <= 1'b0;             // [RL6]
                page_valid_reg <= 1'b0;
                state_reg      <= ST_WR_LOW;
              end
              CMD_RESET: begin
                // Pin falls here so the pulse spans the full count [RL9]
                o_reset_n      <= 1'b0;
                o_chip_sel_n   <= 1'b1;
                o_out_en_n     <= 1'b1;
                page_valid_reg <= 1'b0;
                o_reset_timeout <= 1'b0;
                state_reg      <= ST_RESET_PULSE;
              end
              // Undefined codes are dropped, never sent to the flash [RL8]
              default: state_reg <= ST_IDLE;
            endcase
          end else if (!page_valid_reg) begin
            o_chip_sel_n <= 1'b1;                   // [RL12]
            o_out_en_n   <= 1'b1;
          end
        end
        ST_READ: begin
          cnt_reg <= cnt_reg + 16'h0001;
          if (cnt_reg + 16'h0001 >= 16'(`ACCESS_CYC)) begin
            o_rsp_valid <= 1'b1;
            // Byte mode returns the low byte only [RL15]
            o_rsp_rdata <= word_mode_reg ? data_sync
                                         : {8'h00, data_sync[7:0]};
            o_id_high_volt <= 1'b0;
            if (!page_valid_reg) begin
              o_out_en_n   <= 1'b1;                 // [RL3]
              o_chip_sel_n <= 1'b1;
            end
            state_reg <= ST_IDLE;
          end
        end
        ST_WR_LOW: begin
          cnt_reg <= cnt_reg + 16'h0001;
          if (cnt_reg + 16'h0001 >= 16'(`WE_LOW_CYC)) begin
            o_write_n <= 1'b1;                      // [RL6]
            cnt_reg   <= 16'h0000;
            state_reg <= ST_WR_HIGH;
          end
        end
        ST_WR_HIGH: begin
          cnt_reg <= cnt_reg + 16'h0001;
          if (cnt_reg + 16'h0001 >= 16'(`WE_HIGH_CYC)) begin
            o_chip_sel_n <= 1'b1;
            cnt_reg      <= 16'h0000;
            state_reg    <= ST_RECOVER;
          end
        end
        ST_RECOVER: begin
          cnt_reg <= cnt_reg + 16'h0001;
          if (cnt_reg + 16'h0001 >= 16'(`RECOVER_CYC)) begin
            o_rsp_valid <= 1'b1;
            state_reg   <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Width and protect pins
  // ****************************************************************
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      word_mode_reg       <= 1'b1;
      o_word_mode         <= 1'b1;
      o_protect_accel_pin <= 1'b1;
    end else if (state_reg == ST_IDLE && !i_req_valid) begin
      word_mode_reg       <= i_word_mode;           // [RL14]
      o_word_mode         <= i_word_mode;
      // Low protects outer sector, high restores it [RL16] [RL17] [RL21]
      o_protect_accel_pin <= !i_protect || i_accel;
    end
  end

  // ****************************************************************
  // Data pin drive
  // ****************************************************************
  always_comb begin
    o_data    = wdata_reg;
    o_data_oe = 16'h0000;
    if (state_reg == ST_WR_LOW || state_reg == ST_WR_HIGH) begin
      // Drive only during the write cycle [RL18] [RL13]
      o_data_oe = word_mode_reg ? 16'hffff : 16'h00ff;
    end
  end

  // Line 15 carries byte address in byte mode, data in word mode [RL15]
  always_comb begin
    o_msb_data_or_byte_addr = word_mode_reg ? wdata_reg[15] : byte_addr_reg;
    o_msb_oe = word_mode_reg ? o_data_oe[15] : !o_chip_sel_n;
  end

  assign o_busy = (state_reg != ST_IDLE) || !rdy_sync;

endmodule // flash_host

// ===== sim/flash_host_asserts.sv
// Pin protocol checker for the parallel flash host
`timescale 1ns/100ps
module flash_host_asserts (
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic        i_req_valid,
  input wire logic        o_req_ready,
  input wire logic [2:0]  i_req_cmd,
  input wire logic [22:0] i_req_addr,
  input wire logic [15:0] i_req_wdata,
  input wire logic        o_rsp_valid,
  input wire logic [22:0] o_addr,
  input wire logic        o_chip_sel_n,
  input wire logic        o_out_en_n,
  input wire logic        o_write_n,
  input wire logic        o_reset_n,
  input wire logic        o_word_mode,
  input wire logic [15:0] o_data,
  input wire logic [15:0] o_data_oe,
  input wire logic        o_msb_oe
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic [7:0] low_cnt;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) low_cnt <= 8'h00;
    else if (o_reset_n) low_cnt <= 8'h00;
    else if (low_cnt != 8'hff) low_cnt <= low_cnt + 8'h01;
  end
  sequence s_take(c);
    i_req_valid && o_req_ready && i_req_cmd == c;
  endsequence
  sequence s_strobe;
    !o_write_n && o_addr == $past(i_req_addr) && o_data_oe[7:0] == 8'hff
      && o_data[7:0] == $past(i_req_wdata[7:0]);
  endsequence
  property p_read_bus;
    !o_chip_sel_n && !o_out_en_n |-> o_write_n;
  endproperty
  property p_write_bus;
    !o_write_n |-> !o_chip_sel_n && o_out_en_n;
  endproperty
  property p_no_fight;
    !o_out_en_n |-> o_data_oe[14:0] == 15'h0000;
  endproperty
  property p_pulse;
    $rose(o_reset_n) |-> low_cnt >= 8'h0a;
  endproperty
  property p_sys_reset;
    $fell(i_rst) |-> !o_reset_n [*8];
  endproperty
  property p_read_walk;
    s_take(3'h0) |=> !o_chip_sel_n && !o_out_en_n
      && o_addr == $past(i_req_addr);
  endproperty
  property p_read_rsp;
    s_take(3'h0) |-> ##[1:8] o_rsp_valid;
  endproperty
  property p_write_walk;
    s_take(3'h1) |=> s_strobe ##1 (o_write_n && !o_chip_sel_n)
      ##1 o_chip_sel_n ##1 o_rsp_valid;
  endproperty
  property p_latch_hold;
    $rose(o_write_n) |-> $stable(o_addr) && $stable(o_data) && !o_chip_sel_n;
  endproperty
  property p_byte_pin;
    !o_word_mode && !o_chip_sel_n |-> o_msb_oe;
  endproperty
  a_read_bus: assert property (p_read_bus)
    else $error("read cycle with strobe low");
  a_write_bus: assert property (p_write_bus)
    else $error("strobe low without select or with output enable");
  a_no_fight: assert property (p_no_fight)
    else $error("host drives data while flash outputs enabled");
  a_pulse: assert property (p_pulse)
    else $error("flash reset pulse too short");
  a_sys_reset: assert property (p_sys_reset)
    else $error("flash reset not held after system reset");
  a_read_walk: assert property (p_read_walk)
    else $error("read pins not set after request");
  a_read_rsp: assert property (p_read_rsp)
    else $error("read answer missing");
  a_write_walk: assert property (p_write_walk)
    else $error("write strobe sequence wrong");
  a_latch_hold: assert property (p_latch_hold)
    else $error("address or data moved at strobe rise");
  a_byte_pin: assert property (p_byte_pin)
    else $error("byte address line not driven");
endmodule // flash_host_asserts

bind flash_host flash_host_asserts chk_u (.i_clk, .i_rst, .i_req_valid,
  .o_req_ready, .i_req_cmd, .i_req_addr, .i_req_wdata, .o_rsp_valid, .o_addr,
  .o_chip_sel_n, .o_out_en_n, .o_write_n, .o_reset_n, .o_word_mode, .o_data,
  .o_data_oe, .o_msb_oe);

// ===== sim/flash_model.sv
// Behavioural model of the parallel flash seen from its pins
`timescale 1ns/100ps
module flash_model #(
  parameter int          BUSY_NS = 2000,
  parameter logic [7:0]  MAKER   = 8'h5a,   // Arbitrary code
  parameter logic [15:0] DEV1    = 16'h3c11,
  parameter logic [15:0] DEV2    = 16'h3c12,
  parameter logic [15:0] DEV3    = 16'h3c13
) (
  input  wire logic [22:0] i_addr,
  input  wire logic        i_chip_sel_n,
  input  wire logic        i_out_en_n,
  input  wire logic        i_write_n,
  input  wire logic        i_reset_n,
  input  wire logic        i_word_mode,
  input  wire logic        i_protect_accel_pin,
  input  wire logic        i_id_high_volt,
  input  wire logic        i_hold_busy,
  input  wire logic [15:0] i_bus,
  output logic      [15:0] o_q,
  output logic      [15:0] o_q_oe,
  output logic             o_ready_busy
);
  // ****************************************
  // Array, access timing and pin drivers
  // ****************************************
  logic [15:0] mem [16];
  logic [22:0] wr_addr;
  logic [20:0] hi_late;
  logic [3:0]  lo_late;
  logic        locked;
  logic [15:0] word;
  initial for (int i = 0; i < 16; i++)
    mem[i] = 16'h0f5a ^ (16'h1111 * 16'(i));
  // Data turns valid only once page and in-page addresses settle
  assign #90 hi_late = {i_chip_sel_n, i_addr[22:3]};
  assign #30 lo_late = {i_addr[2:0], !i_word_mode && i_bus[15]};
  // Outer sector was unprotected before, so the pin alone decides
  assign locked = i_addr[22:16] == 7'h7f
    && !i_protect_accel_pin;
  always_comb begin
    word = mem[i_addr[3:0]];
    if (i_id_high_volt && !i_addr[6]) begin
      case (i_addr[3:0])
        4'h0: word = {8'h00, MAKER};
        4'h1: word = DEV1;
        4'he: word = DEV2;
        4'hf: word = DEV3;
        4'h2: word = {15'h0000, locked};
        default: word = 16'h0000;
      endcase
    end
    if (!i_word_mode) word = {8'h00, i_bus[15] ? word[15:8] : word[7:0]};
    if ({i_chip_sel_n, i_addr[22:3]} != hi_late
        || {i_addr[2:0], !i_word_mode && i_bus[15]} != lo_late) word = ~word;
  end
  assign o_q = word;
  assign o_q_oe = !(i_reset_n && !i_chip_sel_n && !i_out_en_n && i_write_n)
    ? 16'h0000
    : i_word_mode ? 16'hffff : 16'h00ff;
  always @(negedge i_write_n)
    if (!i_chip_sel_n && i_reset_n) wr_addr = i_addr;
  always @(posedge i_write_n)
    if (!i_chip_sel_n && i_out_en_n && i_reset_n
        && !(wr_addr[22:16] == 7'h7f && !i_protect_accel_pin))
      mem[wr_addr[3:0]] = i_bus;
  initial o_ready_busy = 1'h0;
  always @(i_reset_n) begin
    if (!i_reset_n) o_ready_busy = 1'h0;
    else begin
      #(BUSY_NS);
      o_ready_busy = i_reset_n && !i_hold_busy;
    end
  end
endmodule // flash_model

// ===== sim/tb_flash_host.sv
// Self-checking testbench for the parallel flash host
`timescale 1ns/100ps
module tb_flash_host;
  import flash_host_pkg::*;
  localparam logic [3:0]  ID_ADR [4] = '{4'h0, 4'h1, 4'he, 4'hf};
  localparam logic [15:0] ID_VAL [4] = '{16'h005a, 16'h3c11, 16'h3c12,
                                         16'h3c13};
  logic        i_clk, i_rst, i_req_valid, i_req_byte_addr, i_word_mode;
  logic        i_protect, i_accel, hold_busy, i_ready_busy_out, o_req_ready;
  logic        o_rsp_valid, o_busy, o_reset_timeout, o_chip_sel_n, o_out_en_n;
  logic        o_write_n, o_reset_n, o_word_mode, o_protect_accel_pin;
  logic        o_id_high_volt, o_msb_data_or_byte_addr, o_msb_oe, g;
  logic [2:0]  i_req_cmd;
  logic [22:0] i_req_addr, o_addr;
  logic [15:0] i_req_wdata, o_rsp_rdata, i_data, o_data, o_data_oe, q, q_oe;
  logic [15:0] bus, flt, d;
  int          error_cnt, cmp_count, cyc;
  flash_host dut_u (.i_clk, .i_rst, .i_req_valid, .o_req_ready, .i_req_cmd,
    .i_req_addr, .i_req_byte_addr, .i_req_wdata, .i_word_mode, .i_protect,
    .i_accel, .o_rsp_valid, .o_rsp_rdata, .o_busy, .o_reset_timeout, .o_addr,
    .o_chip_sel_n, .o_out_en_n, .o_write_n, .o_reset_n, .o_word_mode,
    .o_protect_accel_pin, .o_id_high_volt, .i_data, .o_data, .o_data_oe,
    .o_msb_data_or_byte_addr, .o_msb_oe, .i_ready_busy_out);
  flash_model fm_u (.i_addr(o_addr), .i_chip_sel_n(o_chip_sel_n),
    .i_out_en_n(o_out_en_n), .i_write_n(o_write_n), .i_reset_n(o_reset_n),
    .i_word_mode(o_word_mode), .i_protect_accel_pin(o_protect_accel_pin),
    .i_id_high_volt(o_id_high_volt), .i_hold_busy(hold_busy), .i_bus(bus),
    .o_q(q), .o_q_oe(q_oe), .o_ready_busy(i_ready_busy_out));
  // ****************************************
  // Clock, shared bus and shared tasks
  // ****************************************
  always #25 i_clk = ~i_clk;
  always @(negedge i_clk) flt <= ~flt;
  always_comb begin
    for (int b = 0; b < 16; b++)
      bus[b] = o_data_oe[b] ? o_data[b] : q_oe[b] ? q[b] : flt[b];
    if (o_msb_oe) bus[15] = o_msb_data_or_byte_addr;
  end
  assign i_data = bus;
  task automatic give_verdict();
    if (error_cnt == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      give_verdict();
    end
  end
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] s);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic req(input logic [2:0] c, input logic [22:0] a, input logic ba,
                     input logic [15:0] wd);
    int n;
    g = 1'h0;
    d = 16'h0000;
    @(negedge i_clk);
    {i_req_valid, i_req_cmd, i_req_addr, i_req_byte_addr} = {1'h1, c, a, ba};
    i_req_wdata = wd;
    for (n = 0; n < 900 && o_req_ready !== 1'h1; n++) @(negedge i_clk);
    @(negedge i_clk);
    i_req_valid = 1'h0;
    for (n = 0; n < 20 && !g; n++) begin
      if (o_rsp_valid === 1'h1) {g, d} = {1'h1, o_rsp_rdata};
      else @(negedge i_clk);
    end
  endtask
  task automatic wait_ready();
    for (int n = 0; n < 900 && o_req_ready !== 1'h1; n++) @(negedge i_clk);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    int n;
    for (n = 0; n < 900 && o_req_ready !== 1'h1; n++) @(negedge i_clk);
    chk("ready after busy", 16'h0001, {15'h0000, n >= 50});
    chk("reset timeout", 16'h0000, {15'h0000, o_reset_timeout});
    chk("busy after ready", 16'h0000, {15'h0000, o_busy});
  endtask
  task automatic t_page();
    for (int i = 0; i < 10; i++) begin
      req(3'h0, 23'h050000 + 23'(i), 1'h0, 16'h0000);
      chk("page read", 16'h0f5a ^ (16'h1111 * 16'(i)), d);
    end
  endtask
  task automatic t_write();
    {i_accel, i_protect} = 2'h3;
    req(3'h1, 23'h000003, 1'h0, 16'hbeef);
    chk("write done", 16'h0001, {15'h0000, g});
    chk("accel pin", 16'h0001, {15'h0000, o_protect_accel_pin});
    {i_accel, i_protect} = 2'h0;
    req(3'h0, 23'h000003, 1'h0, 16'h0000);
    chk("write back", 16'hbeef, d);
  endtask
  task automatic t_protect();
    i_protect = 1'h1;
    req(3'h1, 23'h7f0005, 1'h0, 16'h1234);
    req(3'h0, 23'h7f0005, 1'h0, 16'h0000);
    chk("locked write", 16'h5a0f, d);
    req(3'h2, 23'h7f0000, 1'h0, 16'h0000);
    chk("lock outer", 16'h0001, d);
    req(3'h2, 23'h7e0000, 1'h0, 16'h0000);
    chk("lock inner", 16'h0000, d);
    i_protect = 1'h0;
    req(3'h2, 23'h7f0000, 1'h0, 16'h0000);
    chk("lock released", 16'h0000, d);
    req(3'h1, 23'h7f0005, 1'h0, 16'h1234);
    req(3'h0, 23'h7f0005, 1'h0, 16'h0000);
    chk("free write", 16'h1234, d);
  endtask
  task automatic t_ids();
    for (int i = 0; i < 4; i++) begin
      req(3'h3, {19'h00000, ID_ADR[i]}, 1'h0, 16'h0000);
      chk("id word", ID_VAL[i], i == 0 ? {8'h00, d[7:0]} : d);
    end
  endtask
  task automatic t_byte();
    i_word_mode = 1'h0;
    req(3'h0, 23'h000002, 1'h1, 16'h0000);
    chk("byte high", 16'h002d, {8'h00, d[7:0]});
    req(3'h0, 23'h000002, 1'h0, 16'h0000);
    chk("byte low", 16'h0078, {8'h00, d[7:0]});
    i_word_mode = 1'h1;
  endtask
  task automatic t_refuse();
    req(3'h5, 23'h000003, 1'h0, 16'h0000);
    chk("bad command answer", 16'h0000, {15'h0000, g});
    req(3'h4, 23'h000000, 1'h0, 16'h0000);
    wait_ready();
    req(3'h0, 23'h000003, 1'h0, 16'h0000);
    chk("read after reset", 16'hbeef, d);
    hold_busy = 1'h1;
    req(3'h4, 23'h000000, 1'h0, 16'h0000);
    for (int n = 0; n < 900 && o_reset_timeout !== 1'h1; n++)
      @(negedge i_clk);
    chk("stuck busy", 16'h0001, {15'h0000, o_reset_timeout});
    chk("busy while stuck", 16'h0001, {15'h0000, o_busy});
  endtask
  initial begin
    {i_clk, i_rst, i_req_valid, i_req_byte_addr, i_protect} = 5'h08;
    {i_accel, hold_busy, i_word_mode, i_req_cmd} = 6'h08;
    {i_req_addr, i_req_wdata, flt} = '0;
    repeat (2) @(negedge i_clk);
    i_rst = 1'h0;
    t_reset();
    t_page();
    t_write();
    t_protect();
    t_ids();
    t_byte();
    t_refuse();
    give_verdict();
  end
endmodule // tb_flash_host
